/* logic/cvs_params.svh */
// Constants for the converter sync, reset and serial control block
`ifndef CVS_PARAMS_SVH
`define CVS_PARAMS_SVH
// ****************************************
// Register map (byte addresses)
// ****************************************
`define CVS_REG_CTRL        4'h0
`define CVS_REG_STATUS      4'h4
`define CVS_REG_RESULT      4'h8
`define CVS_CTRL_CONT_SYNC  0
`define CVS_CTRL_PIN_MODE   1
`define CVS_CTRL_RESET      2'h0
// ****************************************
// Command opcodes
// ****************************************
`define CVS_OP_WAKEUP       8'h02
`define CVS_OP_STANDBY      8'h04
`define CVS_OP_SYNC         8'h05
`define CVS_OP_RESET        8'h06
`define CVS_OP_CONT_READ    8'h10
`define CVS_OP_STOP_READ    8'h11
`define CVS_OP_READ_ONCE    8'h12
// ****************************************
// Counts and timing
// ****************************************
`define CVS_CLK_NS          20
`define CVS_SUPPRESS_PER    63
`define CVS_TIMEOUT_PER     64
`define CVS_RESET_MIN_CLK   2
`define CVS_RESULT_BITS     32
`define CVS_READY_HIGH_CLK  4
`define CVS_POR_CYCLES      65536
`define CVS_DATA_PERIOD     16384
`define CVS_PIN_BITS        7
`endif

/* logic/cvs_pkg.sv */
// Types for the converter sync, reset and serial control block
package cvs_pkg;
    typedef enum logic [1:0] {
        CVS_STOPPED,
        CVS_SETTLING,
        CVS_RUNNING
    } cvs_conv_e;
endpackage : cvs_pkg

/* logic/cvs_pin_sync.sv */
// Two-flop synchroniser bank for the asynchronous pins
`timescale 1ns/1ps
module cvs_pin_sync #(
    parameter int          WIDTH    = 1,
    parameter logic [15:0] INIT     = 16'h0000
) (
    input  wire logic             clock_i,
    input  wire logic             rst_i,
    input  wire logic             ce_i,
    input  wire logic [WIDTH-1:0] pin_i,
    output logic      [WIDTH-1:0] sync_o
);
    logic [WIDTH-1:0] meta_q;

    initial begin
        if (WIDTH < 1 || WIDTH > 16) $error("cvs_pin_sync: WIDTH out of range");
    end

    always_ff @(posedge clock_i) begin
        if (rst_i) begin
            meta_q <= INIT[WIDTH-1:0];
            sync_o <= INIT[WIDTH-1:0];
        end else if (ce_i) begin
            meta_q <= pin_i;
            sync_o <= meta_q;
        end
    end
endmodule : cvs_pin_sync

/* logic/cvs_ctrl.sv */
// Converter sync, reset, power-down and serial port control with Avalon-MM registers
`timescale 1ns/1ps
`include "cvs_params.svh"
module cvs_ctrl #(
    parameter int POR_CYCLES  = `CVS_POR_CYCLES,
    parameter int DATA_PERIOD = `CVS_DATA_PERIOD,
    parameter int SETTLE_PER  = `CVS_SUPPRESS_PER
) (
    input  wire logic        clock_i,
    input  wire logic        rst_i,
    input  wire logic        ce_i,
    input  wire logic [1:0]  supply_ok_i,
    input  wire logic        sync_pin_i,
    input  wire logic        reset_n_i,
    input  wire logic        power_down_n_i,
    input  wire logic        sclk_i,
    input  wire logic        din_i,
    input  wire logic [31:0] result_i,
    output logic             dout_o,
    output logic             result_ready_n_o,
    output logic             conv_run_o,
    output logic             filter_restart_o,
    input  wire logic [3:0]  avs_address_i,
    input  wire logic        avs_read_i,
    input  wire logic        avs_write_i,
    input  wire logic [31:0] avs_writedata_i,
    input  wire logic [3:0]  avs_byteenable_i,
    output logic [31:0]      avs_readdata_o,
    output logic             avs_waitrequest_o
);
    localparam int PW = $clog2(DATA_PERIOD);
    localparam int CW = $clog2(POR_CYCLES + 1);
    localparam logic [PW-1:0] PH_LAST  = PW'(DATA_PERIOD - 1);
    localparam logic [PW-1:0] PH_WARN  = PW'(DATA_PERIOD - 1 - `CVS_READY_HIGH_CLK);
    localparam logic [CW-1:0] POR_DONE = CW'(POR_CYCLES);
    localparam logic [5:0]    SUPP_N   = 6'(`CVS_SUPPRESS_PER);
    localparam logic [5:0]    SETTLE_N = 6'(SETTLE_PER);
    localparam logic [6:0]    TMO_N    = 7'(`CVS_TIMEOUT_PER);

    initial begin
        if (DATA_PERIOD < 16 || SETTLE_PER < 1 || SETTLE_PER > 63 || POR_CYCLES < 2)
            $error("cvs_ctrl: unsupported parameter value");
    end

    // ****************************************
    // Pin synchronisers
    // ****************************************
    logic [6:0] pins_s;
    // Shift clock and data start at their idle low level: no false edge after reset
    cvs_pin_sync #(.WIDTH(`CVS_PIN_BITS), .INIT(16'h0006)) u_sync (
        .clock_i (clock_i),
        .rst_i   (rst_i),
        .ce_i    (ce_i),
        .pin_i   ({supply_ok_i, din_i, sclk_i, power_down_n_i, reset_n_i, sync_pin_i}),
        .sync_o  (pins_s)
    );
    wire sync_s  = pins_s[0];
    wire rstn_s  = pins_s[1];
    wire pdn_s   = pins_s[2];
    wire sclk_s  = pins_s[3];
    wire din_s   = pins_s[4];
    wire sup_ok  = &pins_s[6:5];

    // ****************************************
    // State
    // ****************************************
    logic [CW-1:0]      por_q;
    logic               sync_d1_q, sclk_d1_q, rlow_q;
    logic [1:0]         ctrl_q;
    logic               standby_q, cont_read_q, rd_once_q, locked_q, boot_q;
    logic [7:0]         cmd_sh_q;
    logic [2:0]         bit_q;
    logic               cmd_v_q;
    logic [PW-1:0]      ph_q;
    logic [5:0]         settle_q, supp_q;
    logic [6:0]         tmo_q;
    logic [31:0]        res_q, tx_q;
    logic               ack_q;
    cvs_pkg::cvs_conv_e conv_q;

    // ****************************************
    // Decode
    // ****************************************
    wire por_busy   = por_q != POR_DONE;
    wire pin_rst    = !rstn_s && rlow_q;
    wire pd         = !pdn_s;
    wire cmd_is_rst = cmd_v_q && cmd_sh_q == `CVS_OP_RESET;
    wire cfg_rst    = por_busy || pin_rst || pd || cmd_is_rst;
    wire pin_mode   = ctrl_q[`CVS_CTRL_PIN_MODE];
    wire cont_sync  = ctrl_q[`CVS_CTRL_CONT_SYNC];
    wire sclk_rise  = sclk_s && !sclk_d1_q;
    wire sclk_fall  = !sclk_s && sclk_d1_q;
    wire din_eff    = din_s && !pin_mode;
    wire byte_done  = sclk_rise && bit_q == 3'h7 && !pin_mode;
    wire pin_edge   = sync_s && !sync_d1_q;
    wire cmd_sync   = cmd_v_q && cmd_sh_q == `CVS_OP_SYNC;
    wire sync_req   = pin_edge || cmd_sync;
    wire per_end    = conv_q != cvs_pkg::CVS_STOPPED && ph_q == PH_LAST;
    wire matched    = cont_sync && locked_q && per_end;
    wire resync     = (sync_req && !matched) || boot_q;
    wire can_run    = !cfg_rst && !standby_q;
    wire timeout    = tmo_q == TMO_N;
    wire deliver    = per_end && !resync && settle_q == 6'h00 && can_run;
    wire to_host    = deliver && (cont_read_q || rd_once_q);
    wire bus_req    = avs_read_i || avs_write_i;
    wire bus_go     = bus_req && ack_q;
    wire [31:0] status_w = {16'h0000, 2'b00, supp_q, 1'b0, locked_q, rd_once_q,
                            cont_read_q, standby_q, pd, pin_rst, por_busy};
    wire [31:0] rdata_w  = avs_address_i == `CVS_REG_CTRL   ? {30'h0, ctrl_q} :
                           avs_address_i == `CVS_REG_STATUS ? status_w :
                           avs_address_i == `CVS_REG_RESULT ? res_q : 32'h0000_0000;

    // ****************************************
    // Power-on and pin reset
    // ****************************************
    always_ff @(posedge clock_i) begin
        if (rst_i || (ce_i && !sup_ok)) begin
            por_q <= '0;
        end else if (ce_i && por_busy) begin
            por_q <= por_q + CW'(1);
        end
    end

    always_ff @(posedge clock_i) begin
        if (rst_i) begin
            sync_d1_q <= 1'b0;
            sclk_d1_q <= 1'b0;
            rlow_q    <= 1'b0;
        end else if (ce_i) begin
            sync_d1_q <= sync_s;
            sclk_d1_q <= sclk_s;
            rlow_q    <= !rstn_s;
        end
    end

    // ****************************************
    // Serial command input
    // ****************************************
    always_ff @(posedge clock_i) begin
        if (rst_i || (ce_i && (timeout || cfg_rst))) begin
            cmd_sh_q <= 8'h00;
            bit_q    <= 3'h0;
            cmd_v_q  <= 1'b0;
        end else if (ce_i) begin
            cmd_v_q <= byte_done;
            if (sclk_rise) begin
                cmd_sh_q <= {cmd_sh_q[6:0], din_eff};
                bit_q    <= bit_q + 3'h1;
            end
        end
    end

    // Timeout counts data periods with the shift clock parked low
    always_ff @(posedge clock_i) begin
        if (rst_i) begin
            tmo_q <= 7'h00;
        end else if (ce_i) begin
            if (sclk_s || timeout) begin
                tmo_q <= 7'h00;
            end else if (per_end) begin
                tmo_q <= tmo_q + 7'h01;
            end
        end
    end

    // ****************************************
    // Configuration and modes
    // ****************************************
    always_ff @(posedge clock_i) begin
        if (rst_i || (ce_i && cfg_rst)) begin
            ctrl_q      <= `CVS_CTRL_RESET;
            standby_q   <= 1'b0;
            cont_read_q <= 1'b1;
            rd_once_q   <= 1'b0;
        end else if (ce_i) begin
            if (bus_go && avs_write_i && avs_byteenable_i[0]
                && avs_address_i == `CVS_REG_CTRL) begin
                ctrl_q <= avs_writedata_i[1:0];
            end
            if (cmd_v_q && cmd_sh_q == `CVS_OP_STANDBY) begin
                standby_q <= 1'b1;
            end else if (cmd_v_q && cmd_sh_q == `CVS_OP_WAKEUP) begin
                standby_q <= 1'b0;
            end
            if (cmd_v_q && cmd_sh_q == `CVS_OP_CONT_READ) begin
                cont_read_q <= 1'b1;
            end else if (cmd_v_q && cmd_sh_q == `CVS_OP_STOP_READ) begin
                cont_read_q <= 1'b0;
            end
            if (cmd_v_q && cmd_sh_q == `CVS_OP_READ_ONCE) begin
                rd_once_q <= 1'b1;
            end else if (to_host) begin
                rd_once_q <= 1'b0;
            end
        end
    end

    // ****************************************
    // Conversion timing and synchronisation
    // ****************************************
    always_ff @(posedge clock_i) begin
        if (rst_i) begin
            conv_q           <= cvs_pkg::CVS_STOPPED;
            ph_q             <= '0;
            settle_q         <= 6'h00;
            supp_q           <= 6'h00;
            locked_q         <= 1'b0;
            boot_q           <= 1'b1;
            filter_restart_o <= 1'b0;
            conv_run_o       <= 1'b0;
        end else if (ce_i) begin
            filter_restart_o <= 1'b0;
            conv_run_o       <= can_run;
            if (!can_run) begin
                conv_q   <= cvs_pkg::CVS_STOPPED;
                ph_q     <= '0;
                locked_q <= 1'b0;
                boot_q   <= 1'b1;
            end else if (resync) begin
                // Pulse mode settles with ready high, continuous mode only mutes data
                filter_restart_o <= 1'b1;
                ph_q             <= '0;
                boot_q           <= 1'b0;
                locked_q         <= cont_sync && !boot_q;
                if (cont_sync) begin
                    conv_q   <= cvs_pkg::CVS_RUNNING;
                    supp_q   <= SUPP_N;
                    settle_q <= 6'h00;
                end else begin
                    conv_q   <= cvs_pkg::CVS_SETTLING;
                    settle_q <= SETTLE_N;
                    supp_q   <= 6'h00;
                end
            end else begin
                ph_q <= per_end ? '0 : ph_q + PW'(1);
                unique case (conv_q)
                    cvs_pkg::CVS_STOPPED: begin
                        conv_q <= cvs_pkg::CVS_RUNNING;
                    end
                    cvs_pkg::CVS_SETTLING: begin
                        if (per_end) begin
                            settle_q <= settle_q - 6'h01;
                            if (settle_q == 6'h01) begin
                                conv_q <= cvs_pkg::CVS_RUNNING;
                            end
                        end
                    end
                    cvs_pkg::CVS_RUNNING: begin
                        if (per_end && supp_q != 6'h00) begin
                            supp_q <= supp_q - 6'h01;
                        end
                    end
                endcase
            end
        end
    end

    // ****************************************
    // Result output and ready strobe
    // ****************************************
    always_ff @(posedge clock_i) begin
        if (rst_i) begin
            res_q            <= 32'h0000_0000;
            tx_q             <= 32'h0000_0000;
            result_ready_n_o <= 1'b1;
        end else if (ce_i) begin
            if (deliver) begin
                res_q <= result_i;
            end
            if (to_host) begin
                // Muted readings shift out as zeros
                tx_q             <= supp_q != 6'h00 ? 32'h0000_0000 : result_i;
                result_ready_n_o <= 1'b0;
            end else begin
                if (sclk_fall || timeout) begin
                    tx_q <= timeout ? 32'h0000_0000 : {tx_q[30:0], 1'b0};
                end
                if (sclk_fall || ph_q == PH_WARN || conv_q != cvs_pkg::CVS_RUNNING
                    || !can_run) begin
                    result_ready_n_o <= 1'b1;
                end
            end
        end
    end

    assign dout_o = tx_q[31];

    // ****************************************
    // Avalon-MM slave, one wait state
    // ****************************************
    always_ff @(posedge clock_i) begin
        if (rst_i) begin
            ack_q             <= 1'b0;
            avs_waitrequest_o <= 1'b1;
            avs_readdata_o    <= 32'h0000_0000;
        end else if (ce_i) begin
            ack_q             <= bus_req && !ack_q;
            avs_waitrequest_o <= !(bus_req && !ack_q);
            if (bus_req && !ack_q && avs_read_i) begin
                avs_readdata_o <= rdata_w;
            end
        end
    end

    // ****************************************
    // Checks
    // ****************************************
    default clocking cb @(posedge clock_i); endclocking
    default disable iff (rst_i || !ce_i);

    por_release_a: assert property ($fell(por_busy) |-> $past(por_q) == POR_DONE - CW'(1))
        else $error("power-on reset released early");
    pin_reset_a: assert property (!rstn_s && rlow_q && !por_busy |=> ctrl_q == `CVS_CTRL_RESET)
        else $error("reset pin did not clear configuration");
    settle_ready_a: assert property (conv_q == cvs_pkg::CVS_SETTLING ##1 conv_q == cvs_pkg::CVS_SETTLING |-> result_ready_n_o)
        else $error("ready low while settling");
    mute_dout_a: assert property (to_host && supp_q != 6'h00 |=> !dout_o)
        else $error("data out not held low while muted");
    pin_sync_a: assert property (pin_edge && can_run && !cont_sync |=> filter_restart_o)
        else $error("pin edge did not restart filter");
    lock_free_a: assert property (matched && can_run && !boot_q |=> !filter_restart_o)
        else $error("matched sync edge caused resync");
    standby_stop_a: assert property (standby_q && !cfg_rst |=> !conv_run_o)
        else $error("conversion running in standby");
    ready_fall_a: assert property (sclk_fall && !to_host |=> result_ready_n_o)
        else $error("ready did not return high on falling shift edge");
    bus_wait_a: assert property ($rose(bus_req) |=> !avs_waitrequest_o ##1 avs_waitrequest_o)
        else $error("waitrequest not one cycle");
    timeout_a: assert property (timeout |=> bit_q == 3'h0 && tx_q == 32'h0000_0000)
        else $error("timeout did not reset serial port");
endmodule : cvs_ctrl

/* sim/cvs_host.sv */
// Host serial controller model for the shift clock and data lines
`timescale 1ns/1ps
module cvs_host (
    input  wire logic clock_i,
    input  wire logic dout_i,
    output logic      sclk_o,
    output logic      din_o
);
    // ****************************************
    // Serial host
    // ****************************************
    // Three clocks per phase: the device samples the pin through two flops
    localparam int HALF = 3;
    initial begin
        sclk_o = 1'b0;
        din_o  = 1'b0;
    end
    task automatic tick(input int n);
        repeat (n) @(posedge clock_i);
    endtask : tick
    // Top n bits of d, most significant first
    task automatic send(input logic [7:0] d, input int n);
        for (int i = 7; i > 7 - n; i--) begin
            din_o  <= d[i];
            tick(HALF);
            sclk_o <= 1'b1;
            tick(HALF);
            sclk_o <= 1'b0;
        end
        din_o <= 1'b0;
        tick(HALF);
    endtask : send
    task automatic read(output logic [31:0] w);
        for (int i = 31; i >= 0; i--) begin
            sclk_o <= 1'b1;
            tick(HALF);
            w[i] = dout_i;
            sclk_o <= 1'b0;
            tick(HALF);
        end
    endtask : read
endmodule : cvs_host

/* sim/cvs_ctrl_test.sv */
// Self-checking bench for the converter sync, reset and serial control block
`timescale 1ns/1ps
`include "cvs_params.svh"
module cvs_ctrl_test;
    // ****************************************
    // Signals and instances
    // ****************************************
    // Short period keeps a 32-bit read inside one period at a safe shift rate
    localparam int          DP  = 256;
    localparam logic [31:0] RES = 32'hA5C3_0F96;
    logic        clock_i, rst_i, sync_pin, reset_n, pd_n, sclk, din, dout, rdy_n, run, restart;
    logic [1:0]  supply_ok;
    logic [3:0]  addr;
    logic        rd, wr, wait_o;
    logic [31:0] wdata, rdata, result, v;
    int          n_fail = 0, tests_run = 0, cycles = 0, n_restart = 0, n, n0;

    // Short settle keeps first data inside the ready wait limit
    cvs_ctrl #(.POR_CYCLES(32), .DATA_PERIOD(DP), .SETTLE_PER(2)) i_cvs_ctrl (
        .clock_i(clock_i), .rst_i(rst_i), .ce_i(1'b1), .supply_ok_i(supply_ok),
        .sync_pin_i(sync_pin), .reset_n_i(reset_n), .power_down_n_i(pd_n),
        .sclk_i(sclk), .din_i(din), .result_i(result), .dout_o(dout),
        .result_ready_n_o(rdy_n), .conv_run_o(run), .filter_restart_o(restart),
        .avs_address_i(addr), .avs_read_i(rd), .avs_write_i(wr), .avs_writedata_i(wdata),
        .avs_byteenable_i(4'hF), .avs_readdata_o(rdata), .avs_waitrequest_o(wait_o));
    cvs_host i_cvs_host (.clock_i(clock_i), .dout_i(dout), .sclk_o(sclk), .din_o(din));

    initial begin
        clock_i = 1'b0;
        forever #10 clock_i = ~clock_i;
    end
    always @(posedge clock_i) begin
        cycles++;
        if (restart === 1'b1) n_restart++;
        if (cycles == 90000) begin
            n_fail++;
            summarize();
        end
    end
    // ****************************************
    // Tasks
    // ****************************************
    task automatic summarize();
        if (n_fail == 0 && tests_run > 0) $display("All tests passed");
        else $display("Some tests failed");
        $finish;
    endtask : summarize
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        tests_run++;
        if (got !== exp) begin
            n_fail++;
            $display("BAD %0t got %h expected %h", $time, got, exp);
        end
    endtask : chk
    // Request held until waitrequest is sampled low
    task automatic bus(input logic w, input logic [3:0] a, input logic [31:0] d);
        int k;
        k = 0;
        addr  <= a;
        wdata <= d;
        wr    <= w;
        rd    <= !w;
        do begin
            @(posedge clock_i);
            k++;
        end while (wait_o !== 1'b0 && k < 50);
        v = rdata;
        wr <= 1'b0;
        rd <= 1'b0;
        // Idle edge so back-to-back calls never rewrite a strobe in one step
        @(posedge clock_i);
        if (k >= 50) begin
            n_fail++;
            $display("BAD %0t bus answer timed out", $time);
        end
    endtask : bus
    task automatic rd_chk(input logic [3:0] a, input logic [31:0] exp);
        bus(1'b0, a, 32'h0000_0000);
        chk(v, exp);
    endtask : rd_chk
    task automatic wait_fall();
        n = 0;
        while (rdy_n !== 1'b1 && n < 4 * DP) begin
            @(posedge clock_i);
            n++;
        end
        while (rdy_n !== 1'b0 && n < 4 * DP) begin
            @(posedge clock_i);
            n++;
        end
    endtask : wait_fall
    task automatic cmd_run(input logic [7:0] op, input logic exp);
        i_cvs_host.send(op, 8);
        repeat (8) @(posedge clock_i);
        chk(run, exp);
    endtask : cmd_run
    // ****************************************
    // Tests
    // ****************************************
    initial begin
        rst_i = 1'b1;
        supply_ok = 2'b00;
        sync_pin = 1'b0;
        reset_n = 1'b1;
        pd_n = 1'b1;
        result = RES;
        addr = 4'h0;
        rd = 1'b0;
        wr = 1'b0;
        wdata = 32'h0000_0000;
        repeat (16) @(posedge clock_i);
        rst_i <= 1'b0;
        supply_ok <= 2'b11;
        rd_chk(`CVS_REG_CTRL, 32'h0000_0000);
        rd_chk(4'hC, 32'h0000_0000);
        n0 = 0;
        do begin
            bus(1'b0, `CVS_REG_STATUS, 32'h0000_0000);
            n0++;
        end while ((v[0] !== 1'b0 || v[13:8] !== 6'h00) && n0 < 20000);
        chk(n0 < 20000, 1'b1);
        chk(n0 > 10, 1'b1);
        wait_fall();
        wait_fall();
        chk(n, DP);
        i_cvs_host.read(v);
        chk(v, RES);
        chk(rdy_n, 1'b1);
        n0 = n_restart;
        sync_pin <= 1'b1;
        repeat (6) @(posedge clock_i);
        chk(n_restart - n0, 1);
        sync_pin <= 1'b0;
        n = 0;
        repeat (2 * DP) begin
            @(posedge clock_i);
            if (rdy_n !== 1'b1) n++;
        end
        chk(n, 0);
        n0 = n_restart;
        i_cvs_host.send(`CVS_OP_SYNC, 8);
        repeat (4) @(posedge clock_i);
        chk(n_restart - n0, 1);
        bus(1'b1, `CVS_REG_CTRL, 32'h0000_0001);
        cmd_run(`CVS_OP_STANDBY, 1'b0);
        rd_chk(`CVS_REG_CTRL, 32'h0000_0001);
        cmd_run(`CVS_OP_WAKEUP, 1'b1);
        bus(1'b1, `CVS_REG_CTRL, 32'h0000_0002);
        cmd_run(`CVS_OP_STANDBY, 1'b1);
        bus(1'b1, `CVS_REG_CTRL, 32'h0000_0001);
        i_cvs_host.send(`CVS_OP_RESET, 8);
        repeat (4) @(posedge clock_i);
        rd_chk(`CVS_REG_CTRL, 32'h0000_0000);
        bus(1'b1, `CVS_REG_CTRL, 32'h0000_0001);
        reset_n <= 1'b0;
        repeat (20) @(posedge clock_i);
        chk(run, 1'b0);
        reset_n <= 1'b1;
        rd_chk(`CVS_REG_CTRL, 32'h0000_0000);
        bus(1'b1, `CVS_REG_CTRL, 32'h0000_0001);
        pd_n <= 1'b0;
        repeat (20) @(posedge clock_i);
        chk(run, 1'b0);
        chk(dout === 1'b0 || dout === 1'b1, 1'b1);
        pd_n <= 1'b1;
        rd_chk(`CVS_REG_CTRL, 32'h0000_0000);
        repeat (16) @(posedge clock_i);
        // A stray half command must be flushed by the idle time-out
        i_cvs_host.send(8'h00, 4);
        repeat (66 * DP) @(posedge clock_i);
        cmd_run(`CVS_OP_STANDBY, 1'b0);
        cmd_run(`CVS_OP_WAKEUP, 1'b1);
        bus(1'b1, `CVS_REG_CTRL, 32'h0000_0001);
        sync_pin <= 1'b1;
        repeat (6) @(posedge clock_i);
        sync_pin <= 1'b0;
        wait_fall();
        wait_fall();
        chk(n < 4 * DP, 1'b1);
        i_cvs_host.read(v);
        chk(v, 32'h0000_0000);
        i_cvs_host.send(`CVS_OP_STOP_READ, 8);
        repeat (DP) @(posedge clock_i);
        n = 0;
        repeat (2 * DP) begin
            @(posedge clock_i);
            if (rdy_n !== 1'b1) n++;
        end
        chk(n, 0);
        i_cvs_host.send(`CVS_OP_READ_ONCE, 8);
        wait_fall();
        chk(rdy_n, 1'b0);
        wait_fall();
        chk(rdy_n, 1'b1);
        i_cvs_host.send(`CVS_OP_CONT_READ, 8);
        wait_fall();
        chk(rdy_n, 1'b0);
        summarize();
    end
endmodule : cvs_ctrl_test
